// >>> isy_params.svh
`ifndef ISY_PARAMS_SVH
`define ISY_PARAMS_SVH
`define ISY_ADDR_MODE 8'h04
`define ISY_ADDR_CYCLE 8'h08
`define ISY_ADDR_SHIFT 8'h0C
`define ISY_ADDR_SUPP 8'h10
`define ISY_ADDR_MINC 8'h14
`define ISY_ADDR_COPY 8'h18
`define ISY_ADDR_MIND 8'h1C
`define ISY_ADDR_CMD 8'h20
`define ISY_ADDR_MAXD 8'h24
`define ISY_ADDR_MISS 8'h2C
`define ISY_ADDR_OVR 8'h30
`define ISY_ADDR_SHORT 8'h34
`define ISY_ADDR_SERR 8'h80
`define ISY_ADDR_ISTAT 8'h90
`define ISY_ADDR_ICLR 8'h94
`define ISY_ADDR_IEN 8'h98
`define ISY_MODE_FREE 16'h0000
`define ISY_MODE_SM_IN 16'h0001
`define ISY_MODE_SYNC0 16'h0002
`define ISY_MODE_SYNC1 16'h0003
`define ISY_MODE_SM_OUT 16'h0022
`define ISY_RST_MODE 16'h0022
`define ISY_RST_CYCLE 32'h000F4240
`define ISY_SUPP_BASE 16'hC007
`define ISY_SHIFT_POS 4
`define ISY_SHIFT_LOCAL 2'h1
`define ISY_SHIFT_SYNC1 2'h2
`define ISY_MIN_CYCLE 32'h000186A0
`define ISY_CMD_START 16'h0001
`define ISY_CLK_PERIOD_NS 32'h00000004
`define ISY_MIN_SHIFT_NS 32'h000003E8
`define ISY_IRQ_MISS 0
`define ISY_IRQ_OVR 1
`define ISY_IRQ_SHORT 2
`define ISY_IRQ_LATE 3
`endif

// >>> isy_pkg.sv
package isy_pkg;
    typedef enum logic [2:0] {SRC_NONE, SRC_LOCAL, SRC_SM_IN, SRC_SM_OUT, SRC_SYNC0, SRC_SYNC1} isy_src_t;
    typedef enum logic [1:0] {MS_IDLE, MS_CLEAR, MS_RUN} isy_meas_t;
endpackage

// >>> isy_input_sync_monitor.sv
`timescale 1ns/1ps
`include "isy_params.svh"
module isy_input_sync_monitor #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_state,
    input wire logic sm_in_evt,
    input wire logic sm_out_evt,
    input wire logic sync0_evt,
    input wire logic sync1_evt,
    input wire logic sample_done_evt,
    input wire logic inputs_ready_evt,
    input wire logic outputs_late_evt,
    output logic sample_trigger,
    output logic local_tick,
    output logic irq
);
    logic [15:0] mode_reg;
    logic [31:0] cycle_reg;
    logic [15:0] cmd_reg;
    logic [31:0] shift_max_reg;
    logic [31:0] copy_max_reg;
    logic [31:0] delay_max_reg;
    logic [CNT_W-1:0] miss_cnt_reg;
    logic [CNT_W-1:0] ovr_cnt_reg;
    logic [CNT_W-1:0] short_cnt_reg;
    logic late_flag_reg;
    logic late_pend_reg;
    logic sm_seen_reg;
    logic armed_reg;
    logic busy_reg;
    logic [31:0] t0_reg;
    logic [31:0] t1_reg;
    logic [31:0] ts_reg;
    logic [31:0] lt_reg;
    logic [3:0] istat_reg;
    logic [3:0] ien_reg;
    logic phase_reg;
    logic err_reg;
    logic [31:0] rdata_reg;
    logic trig_reg;
    logic tick_reg;
    isy_pkg::isy_meas_t meas_reg;
    isy_pkg::isy_meas_t meas_next;
    isy_pkg::isy_src_t src;

    function automatic logic [31:0] sat_add(input logic [31:0] a);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, `ISY_CLK_PERIOD_NS};
        sat_add = s[32] ? 32'hFFFFFFFF : s[31:0];
    endfunction

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
        sat_inc = (&c) ? c : c + {{(CNT_W-1){1'b0}}, 1'b1};
    endfunction

    // The answer comes one edge after setup so that read data leaves a flip-flop.
    wire setup = psel & ~penable & clk_en;
    wire done = psel & penable & pready;
    wire wr_done = done & pwrite;
    wire sel_mode = paddr == `ISY_ADDR_MODE;
    wire sel_cycle = paddr == `ISY_ADDR_CYCLE;
    wire sel_cmd = paddr == `ISY_ADDR_CMD;
    wire sel_iclr = paddr == `ISY_ADDR_ICLR;
    wire sel_ien = paddr == `ISY_ADDR_IEN;
    wire [CNT_W-1:0] cnt_max = {CNT_W{1'b1}};
    assign pready = clk_en & phase_reg;
    assign prdata = rdata_reg;
    assign pslverr = pready & err_reg;
    assign sample_trigger = trig_reg;
    assign local_tick = tick_reg;

    always_comb
    begin
        case (mode_reg)
            `ISY_MODE_FREE: src = isy_pkg::SRC_LOCAL;
            `ISY_MODE_SM_IN: src = isy_pkg::SRC_SM_IN;
            `ISY_MODE_SYNC0: src = isy_pkg::SRC_SYNC0;
            `ISY_MODE_SYNC1: src = isy_pkg::SRC_SYNC1;
            `ISY_MODE_SM_OUT: src = isy_pkg::SRC_SM_OUT;
            default: src = isy_pkg::SRC_NONE;
        endcase
    end

    wire dc_mode = (src == isy_pkg::SRC_SYNC0) | (src == isy_pkg::SRC_SYNC1);
    wire lt_wrap = (src == isy_pkg::SRC_LOCAL) & (sat_add(lt_reg) >= cycle_reg);
    wire trig = (src == isy_pkg::SRC_LOCAL) ? lt_wrap :
                (src == isy_pkg::SRC_SM_IN) ? sm_in_evt :
                (src == isy_pkg::SRC_SM_OUT) ? sm_out_evt :
                (src == isy_pkg::SRC_SYNC0) ? sync0_evt :
                (src == isy_pkg::SRC_SYNC1) ? sync1_evt : 1'b0;
    wire miss_hit = op_state & dc_mode & sync0_evt & armed_reg & ~sm_seen_reg & ~sm_in_evt & ~sm_out_evt;
    wire ovr_hit = op_state & trig & busy_reg;
    wire short_hit = dc_mode & sync1_evt & armed_reg & (t0_reg < `ISY_MIN_SHIFT_NS);
    wire late_set = dc_mode & sync0_evt & (late_pend_reg | outputs_late_evt);
    wire [3:0] hits = {late_set, short_hit, ovr_hit, miss_hit};
    wire meas_on = (meas_reg == isy_pkg::MS_RUN) & dc_mode;

    wire [1:0] shift_src = (src == isy_pkg::SRC_SYNC1) ? `ISY_SHIFT_SYNC1 :
                           (src == isy_pkg::SRC_SYNC0) ? `ISY_SHIFT_LOCAL : 2'h0;
    wire [15:0] supp = `ISY_SUPP_BASE | ({14'h0000, shift_src} << `ISY_SHIFT_POS);
    wire [31:0] rd_mux =
        sel_mode ? {16'h0000, mode_reg} :
        sel_cycle ? cycle_reg :
        (paddr == `ISY_ADDR_SHIFT) ? shift_max_reg :
        (paddr == `ISY_ADDR_SUPP) ? {16'h0000, supp} :
        (paddr == `ISY_ADDR_MINC) ? `ISY_MIN_CYCLE :
        (paddr == `ISY_ADDR_COPY) ? copy_max_reg :
        sel_cmd ? {16'h0000, cmd_reg} :
        (paddr == `ISY_ADDR_MAXD) ? delay_max_reg :
        (paddr == `ISY_ADDR_MISS) ? 32'(miss_cnt_reg) :
        (paddr == `ISY_ADDR_OVR) ? 32'(ovr_cnt_reg) :
        (paddr == `ISY_ADDR_SHORT) ? 32'(short_cnt_reg) :
        (paddr == `ISY_ADDR_SERR) ? {31'h00000000, late_flag_reg} :
        (paddr == `ISY_ADDR_ISTAT) ? {28'h0000000, istat_reg} :
        sel_ien ? {28'h0000000, ien_reg} : 32'h00000000;
    wire addr_ok = sel_mode | sel_cycle | sel_cmd | sel_iclr | sel_ien |
                   (paddr == `ISY_ADDR_SHIFT) | (paddr == `ISY_ADDR_SUPP) | (paddr == `ISY_ADDR_MINC) |
                   (paddr == `ISY_ADDR_COPY) | (paddr == `ISY_ADDR_MIND) | (paddr == `ISY_ADDR_MAXD) |
                   (paddr == `ISY_ADDR_MISS) | (paddr == `ISY_ADDR_OVR) | (paddr == `ISY_ADDR_SHORT) |
                   (paddr == `ISY_ADDR_SERR) | (paddr == `ISY_ADDR_ISTAT);

    always_comb
    begin
        meas_next = meas_reg;
        case (meas_reg)
            isy_pkg::MS_IDLE: if (wr_done & sel_cmd & (pwdata[15:0] == `ISY_CMD_START)) meas_next = isy_pkg::MS_CLEAR;
            isy_pkg::MS_CLEAR: meas_next = isy_pkg::MS_RUN;
            isy_pkg::MS_RUN: if (wr_done & sel_cmd & (pwdata[15:0] != `ISY_CMD_START)) meas_next = isy_pkg::MS_IDLE;
            default: meas_next = isy_pkg::MS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end
        else if (clk_en)
        begin
            phase_reg <= setup | (phase_reg & ~done);
            if (setup)
            begin
                rdata_reg <= pwrite ? 32'h00000000 : rd_mux;
                err_reg <= ~addr_ok;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg <= `ISY_RST_MODE;
            cycle_reg <= `ISY_RST_CYCLE;
            cmd_reg <= 16'h0000;
            ien_reg <= 4'h0;
            meas_reg <= isy_pkg::MS_IDLE;
        end
        else if (clk_en)
        begin
            meas_reg <= meas_next;
            if (wr_done & sel_mode)
                mode_reg <= pwdata[15:0];
            if (wr_done & sel_cycle)
                cycle_reg <= pwdata;
            if (wr_done & sel_cmd)
                cmd_reg <= pwdata[15:0];
            if (wr_done & sel_ien)
                ien_reg <= pwdata[3:0];
        end
    end

    // Timers run in ns so that captured values need no scaling on read.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            t0_reg <= 32'h00000000;
            t1_reg <= 32'h00000000;
            ts_reg <= 32'h00000000;
            lt_reg <= 32'h00000000;
            trig_reg <= 1'b0;
            tick_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            t0_reg <= sync0_evt ? 32'h00000000 : sat_add(t0_reg);
            t1_reg <= sync1_evt ? 32'h00000000 : sat_add(t1_reg);
            ts_reg <= sample_done_evt ? 32'h00000000 : sat_add(ts_reg);
            lt_reg <= (lt_wrap | (src != isy_pkg::SRC_LOCAL)) ? 32'h00000000 : sat_add(lt_reg);
            tick_reg <= lt_wrap;
            trig_reg <= trig;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_max_reg <= 32'h00000000;
            delay_max_reg <= 32'h00000000;
            copy_max_reg <= 32'h00000000;
        end
        else if (clk_en)
        begin
            if (meas_reg == isy_pkg::MS_CLEAR)
            begin
                shift_max_reg <= 32'h00000000;
                delay_max_reg <= 32'h00000000;
                copy_max_reg <= 32'h00000000;
            end
            else if (meas_on)
            begin
                if (sample_done_evt & (t0_reg > shift_max_reg))
                    shift_max_reg <= t0_reg;
                if (sample_done_evt & (t1_reg > delay_max_reg))
                    delay_max_reg <= t1_reg;
                if (inputs_ready_evt & (ts_reg > copy_max_reg))
                    copy_max_reg <= ts_reg;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            miss_cnt_reg <= '0;
            ovr_cnt_reg <= '0;
            short_cnt_reg <= '0;
        end
        else if (clk_en)
        begin
            if (miss_hit)
                miss_cnt_reg <= sat_inc(miss_cnt_reg);
            if (ovr_hit)
                ovr_cnt_reg <= sat_inc(ovr_cnt_reg);
            if (short_hit)
                short_cnt_reg <= sat_inc(short_cnt_reg);
        end
    end

    // A late pulse in the same cycle as SYNC0 is charged to the cycle just ending.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            late_flag_reg <= 1'b0;
            late_pend_reg <= 1'b0;
            sm_seen_reg <= 1'b0;
            armed_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!dc_mode)
                late_flag_reg <= 1'b0;
            else if (sync0_evt)
                late_flag_reg <= late_set;
            late_pend_reg <= ~sync0_evt & (late_pend_reg | outputs_late_evt);
            sm_seen_reg <= ~sync0_evt & (sm_seen_reg | sm_in_evt | sm_out_evt);
            armed_reg <= dc_mode & (armed_reg | sync0_evt);
            busy_reg <= trig | (busy_reg & ~inputs_ready_evt);
        end
    end

    // Set wins over a clear written in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            istat_reg <= 4'h0;
        else if (clk_en)
            istat_reg <= (istat_reg & ~((wr_done & sel_iclr) ? pwdata[3:0] : 4'h0)) | hits;
    end

    assign irq = |(istat_reg & ien_reg);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_cmd_start;
        clk_en && wr_done && sel_cmd && pwdata[15:0] == `ISY_CMD_START && meas_reg == isy_pkg::MS_IDLE;
    endsequence
    sequence s_cleared;
        meas_reg == isy_pkg::MS_CLEAR ##1 shift_max_reg == 32'h00000000 && copy_max_reg == 32'h00000000;
    endsequence

    AST_SYNC0_TRIGGER: assert property (clk_en && mode_reg == `ISY_MODE_SYNC0 && sync0_evt |=> sample_trigger)
        else $error("SYNC0 mode did not trigger sampling");
    AST_FREE_TICK: assert property (clk_en && lt_wrap |=> local_tick && lt_reg == 32'h00000000)
        else $error("Local timer did not wrap at the cycle period");
    AST_SUPP_READ: assert property (setup && !pwrite && paddr == `ISY_ADDR_SUPP && src == isy_pkg::SRC_SYNC1
        |=> prdata == 32'h0000C027)
        else $error("Supported modes word has wrong shift field");
    AST_MIN_CYCLE: assert property (setup && !pwrite && paddr == `ISY_ADDR_MINC |=> prdata == `ISY_MIN_CYCLE)
        else $error("Minimum cycle read wrong");
    AST_MEAS_CLEAR: assert property (s_cmd_start |=> s_cleared)
        else $error("Maxima not cleared at measurement start");
    AST_MAX_HOLD: assert property (clk_en && meas_on && sample_done_evt && t0_reg > shift_max_reg
        |=> shift_max_reg == $past(t0_reg))
        else $error("Shift maximum not taken");
    AST_MISS_COUNT: assert property (clk_en && miss_hit && miss_cnt_reg != cnt_max
        |=> miss_cnt_reg == $past(miss_cnt_reg) + 1'b1)
        else $error("Missed event not counted");
    AST_OVR_COUNT: assert property (clk_en && op_state && trig && busy_reg && ovr_cnt_reg != cnt_max
        |=> ovr_cnt_reg != $past(ovr_cnt_reg))
        else $error("Overrun not counted");
    AST_SHORT_IRQ: assert property (clk_en && short_hit |=> istat_reg[`ISY_IRQ_SHORT])
        else $error("Short spacing not flagged");
    AST_LATE_FLAG: assert property (clk_en && dc_mode && sync0_evt && late_pend_reg |=> late_flag_reg)
        else $error("Late output flag not set");
    AST_SATURATE: assert property (short_cnt_reg == cnt_max |=> short_cnt_reg == cnt_max)
        else $error("Counter wrapped");
    AST_CYCLE_WRITE: assert property (clk_en && wr_done && sel_cycle |=> cycle_reg == $past(pwdata))
        else $error("Cycle period write not taken");
    AST_SUPP_BASE: assert property (setup && !pwrite && paddr == `ISY_ADDR_SUPP
        |=> (prdata[15:0] & 16'hFFCF) == `ISY_SUPP_BASE && prdata[31:16] == 16'h0000)
        else $error("Supported modes word has wrong fixed bits");
    AST_DELAY_HOLD: assert property (clk_en && meas_on && sample_done_evt && t1_reg > delay_max_reg
        |=> delay_max_reg == $past(t1_reg))
        else $error("SYNC1 delay maximum not taken");
    AST_COPY_HOLD: assert property (clk_en && meas_on && inputs_ready_evt && ts_reg > copy_max_reg
        |=> copy_max_reg == $past(ts_reg))
        else $error("Copy time maximum not taken");
    AST_MEAS_STOP: assert property (clk_en && wr_done && sel_cmd && pwdata[15:0] != `ISY_CMD_START
        && meas_reg == isy_pkg::MS_RUN |=> meas_reg == isy_pkg::MS_IDLE)
        else $error("Measurement did not stop");
    AST_DC_ONLY: assert property (clk_en && !dc_mode && meas_reg != isy_pkg::MS_CLEAR
        |=> shift_max_reg == $past(shift_max_reg))
        else $error("Shift maximum moved outside DC mode");
    AST_SHORT_COUNT: assert property (clk_en && short_hit && short_cnt_reg != cnt_max
        |=> short_cnt_reg == $past(short_cnt_reg) + 1'b1)
        else $error("Short spacing not counted");
    AST_LATE_OFF: assert property (clk_en && !dc_mode |=> !late_flag_reg)
        else $error("Late output flag set outside DC mode");
    AST_MISS_IRQ: assert property (clk_en && miss_hit |=> istat_reg[`ISY_IRQ_MISS])
        else $error("Missed event not flagged");
    AST_OVR_IRQ: assert property (clk_en && ovr_hit |=> istat_reg[`ISY_IRQ_OVR])
        else $error("Overrun not flagged");
endmodule // isy_input_sync_monitor

// >>> isy_master_model.sv
`timescale 1ns/1ps
module isy_master_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end

    // One register read or write issued per call.
    // The request is held until pready is seen at an edge, so slow answers are safe.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule // isy_master_model

// >>> tb_top.sv
`timescale 1ns/1ps
`include "isy_params.svh"
module tb_top;
    logic pclk;
    logic presetn;
    logic op_state;
    logic [6:0] ev;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sample_trigger;
    logic local_tick;
    logic irq;
    logic [31:0] q;
    logic e;
    int num_errors;
    int check_count;
    int cyc;
    int ticks;
    logic [15:0] md [4] = '{16'h0003, 16'h0022, 16'h0001, 16'h0002};
    int ei [4] = '{3, 1, 0, 2};
    logic [31:0] sup [4] = '{32'h0000C027, 32'h0000C007, 32'h0000C007, 32'h0000C017};

    always #2 pclk = ~pclk;

    isy_master_model i_mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    isy_input_sync_monitor i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_state(op_state), .sm_in_evt(ev[0]), .sm_out_evt(ev[1]),
        .sync0_evt(ev[2]), .sync1_evt(ev[3]), .sample_done_evt(ev[4]), .inputs_ready_evt(ev[5]),
        .outputs_late_evt(ev[6]), .sample_trigger(sample_trigger), .local_tick(local_tick), .irq(irq));

    task automatic end_of_test;
        $display("Mismatches %0d, comparisons %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_mst.xfer(1'b1, a, d, q, e);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        i_mst.xfer(1'b0, a, 32'h00000000, q, e);
        chk(q, x);
        chk({31'h0, e}, 32'h00000000);
    endtask

    // Measured times depend on pipeline depth, so only a plausible window is demanded.
    task automatic rr(input logic [7:0] a);
        i_mst.xfer(1'b0, a, 32'h00000000, q, e);
        chk({31'h0, (q > 0 && q < 200)}, 32'h00000001);
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
        #1;
    endtask

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        op_state = 1'b0;
        ev = 7'h00;
        num_errors = 0;
        check_count = 0;
        cyc = 0;
        ticks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rc(`ISY_ADDR_MODE, 32'h00000022);
        rc(`ISY_ADDR_CYCLE, 32'h000F4240);
        rc(`ISY_ADDR_SUPP, 32'h0000C007);
        rc(`ISY_ADDR_MINC, 32'h000186A0);
        rc(`ISY_ADDR_SHIFT, 32'h00000000);
        rc(`ISY_ADDR_COPY, 32'h00000000);
        rc(`ISY_ADDR_MAXD, 32'h00000000);
        rc(`ISY_ADDR_MISS, 32'h00000000);
        rc(`ISY_ADDR_OVR, 32'h00000000);
        rc(`ISY_ADDR_SHORT, 32'h00000000);
        rc(`ISY_ADDR_SERR, 32'h00000000);
        rc(`ISY_ADDR_CMD, 32'h00000000);
        i_mst.xfer(1'b0, 8'h00, 32'h00000000, q, e);
        chk({31'h0, e}, 32'h00000001);
        chk(q, 32'h00000000);
        wr(`ISY_ADDR_MINC, 32'h00000000);
        rc(`ISY_ADDR_MINC, 32'h000186A0);
        for (int i = 0; i < 4; i++)
        begin
            wr(`ISY_ADDR_MODE, {16'h0000, md[i]});
            pulse(ei[i]);
            chk({31'h0, sample_trigger}, 32'h00000001);
            rc(`ISY_ADDR_SUPP, sup[i]);
        end
        pulse(2);
        pulse(3);
        rc(`ISY_ADDR_SHORT, 32'h00000001);
        chk({31'h0, irq}, 32'h00000000);
        wr(`ISY_ADDR_IEN, 32'h0000000F);
        #1;
        chk({31'h0, irq}, 32'h00000001);
        pulse(5);
        @(posedge pclk);
        op_state <= 1'b1;
        pulse(0);
        pulse(6);
        pulse(2);
        rc(`ISY_ADDR_SERR, 32'h00000001);
        rc(`ISY_ADDR_MISS, 32'h00000000);
        pulse(2);
        rc(`ISY_ADDR_MISS, 32'h00000001);
        rc(`ISY_ADDR_OVR, 32'h00000001);
        rc(`ISY_ADDR_SERR, 32'h00000000);
        rc(`ISY_ADDR_ISTAT, 32'h0000000F);
        wr(`ISY_ADDR_ICLR, 32'h0000000F);
        rc(`ISY_ADDR_ISTAT, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        wr(`ISY_ADDR_CMD, 32'h00000001);
        pulse(2);
        pulse(3);
        repeat (3) @(posedge pclk);
        pulse(4);
        repeat (2) @(posedge pclk);
        pulse(5);
        rr(`ISY_ADDR_SHIFT);
        rr(`ISY_ADDR_MAXD);
        rr(`ISY_ADDR_COPY);
        wr(`ISY_ADDR_CMD, 32'h00000000);
        wr(`ISY_ADDR_CMD, 32'h00000001);
        rc(`ISY_ADDR_SHIFT, 32'h00000000);
        rc(`ISY_ADDR_MAXD, 32'h00000000);
        rc(`ISY_ADDR_COPY, 32'h00000000);
        wr(`ISY_ADDR_CYCLE, 32'h00000028);
        wr(`ISY_ADDR_MODE, 32'h00000000);
        repeat (100)
        begin
            @(posedge pclk);
            ticks += int'(local_tick);
        end
        chk({31'h0, (ticks >= 9 && ticks <= 11)}, 32'h00000001);
        rc(`ISY_ADDR_CYCLE, 32'h00000028);
        rc(`ISY_ADDR_SHORT, 32'h00000002);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rc(`ISY_ADDR_MODE, 32'h00000022);
        rc(`ISY_ADDR_CYCLE, 32'h000F4240);
        rc(`ISY_ADDR_MISS, 32'h00000000);
        rc(`ISY_ADDR_OVR, 32'h00000000);
        rc(`ISY_ADDR_SHORT, 32'h00000000);
        rc(`ISY_ADDR_ISTAT, 32'h00000000);
        end_of_test();
    end
endmodule // tb_top
